// ===== test_timer8_dual_compare_pwm.sv
// testbench of the 8-bit dual compare timer, sequences of port calls
// assumes tmr8_core, tmr8_partner and the bound checker are compiled
module test_timer8_dual_compare_pwm;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, pwr, wmb, wa, wb, ext, pen, dn;
  logic [1:0] wma, coma, comb, frc;
  logic [2:0] cs, fclr, fsrv, msk, flg, req;
  logic [7:0] cnt, ca, cb, mx, pv;
  tmr8_pkg::tmr8_wr_t cw, aw, bw;
  int num_errors, num_checks, i, k;
  int nt [7] = '{10, 80, 640, 2560, 10240, 60, 60};
  logic [2:0] wt [3] = '{3'h2, 3'h7, 3'h5};
  tmr8_core tmr8_core_i (.CLOCK_IN(clk), .RST_IN(rst),
    .TIMER_POWER_OFF_IN(pwr), .TIMER_CTRL_A_WAVEFORM_MODE_IN(wma),
    .TIMER_CTRL_B_WAVEFORM_MODE_IN(wmb), .CLOCK_SELECT_IN(cs),
    .COMPARE_OUTPUT_MODE_A_IN(coma), .COMPARE_OUTPUT_MODE_B_IN(comb),
    .FORCE_COMPARE_IN(frc), .EXT_COUNT_PIN_IN(ext),
    .COUNT_VALUE_WR_IN(cw), .COMPARE_REG_A_WR_IN(aw),
    .COMPARE_REG_B_WR_IN(bw), .IRQ_FLAG_REG_CLEAR_IN(fclr),
    .IRQ_SERVICED_IN(fsrv), .IRQ_MASK_REG_IN(msk),
    .COUNT_VALUE_OUT(cnt), .COMPARE_REG_A_OUT(ca), .COMPARE_REG_B_OUT(cb),
    .IRQ_FLAG_REG_OUT(flg), .IRQ_REQ_OUT(req), .WAVE_OUT_A_OUT(wa),
    .WAVE_OUT_B_OUT(wb));
  tmr8_partner tmr8_partner_i (.clock_in(clk), .enable_in(pen),
    .ext_pin_out(ext));
  // ****
  // tasks: all start and end at a falling edge
  // ****
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task wr(input logic [1:0] r, input logic [7:0] d);
    if (r == 2'h0) cw = {1'b1, d};
    if (r == 2'h1) aw = {1'b1, d};
    if (r == 2'h2) bw = {1'b1, d};
    cyc(1);
    if (r == 2'h0) cw.wr = 1'b0;
    if (r == 2'h1) aw.wr = 1'b0;
    if (r == 2'h2) bw.wr = 1'b0;
  endtask : wr
  task mode(input logic [2:0] m);
    wmb = m[2];
    wma = m[1:0];
  endtask : mode
  task run(input int n);
    mx = 8'h00;
    dn = 1'b0;
    pv = cnt;
    repeat (n) begin
      cyc(1);
      if (cnt > mx) mx = cnt;
      if (cnt == pv - 8'h01) dn = 1'b1;
      pv = cnt;
    end
  endtask : run
  task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk8
  task chk1(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %b got %b", n, e, g);
    end
  endtask : chk1
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    cyc(30000);
    num_errors++;
    tally_and_finish;
  end
  initial begin
    {rst, pwr, wmb, pen, wma, coma, comb, frc} = 12'h800;
    {cs, fclr, fsrv, msk} = 12'h000;
    {cw, aw, bw} = 27'h0;
    num_errors = 0;
    num_checks = 0;
    cyc(12);
    rst = 1'b0;
    wr(2'h0, 8'h10);
    cyc(12);
    chk8("count_stop", 8'h10, cnt);
    msk = 3'h1;
    wr(2'h0, 8'hf0);
    cs = 3'h1;
    for (i = 0; i < 40 && flg[0] !== 1'b1; i++) cyc(1);
    chk1("ovf_flag", 1'b1, flg[0]);
    chk1("ovf_at_zero", 1'b1, cnt < 8'h03);
    chk1("ovf_req", 1'b1, req[0]);
    msk = 3'h0;
    cyc(2);
    chk1("req_masked", 1'b0, req[0]);
    cs = 3'h0;
    $display("test overflow done");
    wr(2'h1, 8'h20);
    cyc(2);
    chk8("cmp_a_direct", 8'h20, ca);
    coma = 2'h1;
    wr(2'h0, 8'h20);
    fclr = 3'h7;
    cyc(1);
    fclr = 3'h0;
    cyc(2);
    chk8("flags_clear", 8'h00, {5'h00, flg});
    cs = 3'h1;
    cyc(8);
    cs = 3'h0;
    chk1("blocked_flag", 1'b0, flg[1]);
    chk1("blocked_wave", 1'b0, wa);
    wr(2'h2, 8'h22);
    comb = 2'h3;
    wr(2'h0, 8'h1e);
    cs = 3'h1;
    for (i = 0; i < 20 && flg[2] !== 1'b1; i++) cyc(1);
    cs = 3'h0;
    cyc(3);
    chk1("match_flag_a", 1'b1, flg[1]);
    chk1("toggle_a", 1'b1, wa);
    chk1("set_b", 1'b1, wb);
    fsrv = 3'h2;
    cyc(1);
    fsrv = 3'h0;
    cyc(2);
    chk1("serviced", 1'b0, flg[1]);
    $display("test match done");
    pv = cnt;
    coma = 2'h2;
    frc = 2'h1;
    cyc(1);
    frc = 2'h0;
    cyc(3);
    chk1("force_clear", 1'b0, wa);
    chk1("force_noflag", 1'b0, flg[1]);
    chk8("force_count", pv, cnt);
    mode(3'h3);
    coma = 2'h3;
    frc = 2'h1;
    cyc(1);
    frc = 2'h0;
    cyc(3);
    chk1("force_pwm", 1'b0, wa);
    $display("test force done");
    wr(2'h1, 8'h55);
    cyc(4);
    chk8("cmp_buffered", 8'h20, ca);
    wr(2'h0, 8'hf8);
    cs = 3'h1;
    for (i = 0; i < 20 && ca !== 8'h55; i++) cyc(1);
    cs = 3'h0;
    chk8("cmp_copied", 8'h55, ca);
    chk1("copy_at_top", 1'b1, cnt < 8'h02 || cnt == 8'hff);
    $display("test buffer done");
    for (k = 0; k < 3; k++) begin
      mode(wt[k]);
      wr(2'h1, 8'h05);
      if (k == 0) wr(2'h2, 8'h02);
      if (k == 0) wr(2'h0, 8'h00);
      if (k == 0) fclr = 3'h1;
      comb = 2'h2;
      cs = 3'h1;
      cyc(1);
      fclr = 3'h0;
      run(40);
      chk8("top_a", 8'h05, mx);
      if (k == 0) chk1("ctc_no_ovf", 1'b0, flg[0]);
      for (i = 0; i < 12 && cnt !== 8'h05; i++) cyc(1);
      chk1("wave_b_at_top", 1'b0, wb);
    end
    chk1("dual_slope", 1'b1, dn);
    cs = 3'h0;
    $display("test modes done");
    mode(3'h0);
    for (k = 0; k < 7; k++) begin
      wr(2'h0, 8'h00);
      cs = 3'(k + 1);
      pen = (k > 4);
      cyc(nt[k]);
      cs = 3'h0;
      pen = 1'b0;
      cyc(4);
      chk1("tick_rate", 1'b1, cnt >= 8'h09 && cnt <= 8'h0b);
    end
    pwr = 1'b1;
    wr(2'h0, 8'h00);
    cs = 3'h1;
    cyc(20);
    chk8("power_off", 8'h00, cnt);
    $display("test clock select done");
    tally_and_finish;
  end
endmodule : test_timer8_dual_compare_pwm

// ===== tmr8_assertions.sv
// checker of port timing for the 8-bit dual compare timer
// assumes it is bound to tmr8_core on a single clock domain
module tmr8_assertions (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic TIMER_POWER_OFF_IN,
  input wire logic [1:0] TIMER_CTRL_A_WAVEFORM_MODE_IN,
  input wire logic TIMER_CTRL_B_WAVEFORM_MODE_IN,
  input wire logic [2:0] CLOCK_SELECT_IN,
  input wire logic [1:0] COMPARE_OUTPUT_MODE_A_IN,
  input wire tmr8_pkg::tmr8_wr_t COUNT_VALUE_WR_IN,
  input wire tmr8_pkg::tmr8_wr_t COMPARE_REG_A_WR_IN,
  input wire logic [2:0] IRQ_FLAG_REG_CLEAR_IN,
  input wire logic [2:0] IRQ_SERVICED_IN,
  input wire logic [2:0] IRQ_MASK_REG_IN,
  input wire logic [7:0] COUNT_VALUE_OUT,
  input wire logic [7:0] COMPARE_REG_A_OUT,
  input wire logic [2:0] IRQ_FLAG_REG_OUT,
  input wire logic [2:0] IRQ_REQ_OUT,
  input wire logic WAVE_OUT_A_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wm;
  logic wr;
  logic [2:0] clr;
  assign wm = {TIMER_CTRL_B_WAVEFORM_MODE_IN, TIMER_CTRL_A_WAVEFORM_MODE_IN};
  assign wr = COUNT_VALUE_WR_IN.wr;
  assign clr = IRQ_FLAG_REG_CLEAR_IN | IRQ_SERVICED_IN;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  // ****
  // assertions and cover points
  // ****
  // four idle cycles let the tick pipeline drain first
  a_stop_count_hold: assert property ((CLOCK_SELECT_IN == 3'h0 && !wr)[*4]
    |=> $stable(COUNT_VALUE_OUT)) else $error("count moved while stopped");
  a_write_lands: assert property (wr |-> ##1
    COUNT_VALUE_OUT == $past(COUNT_VALUE_WR_IN.data))
    else $error("count write not seen");
  a_up_step: assert property ((wm == 3'h0 && CLOCK_SELECT_IN == 3'h1
    && !TIMER_POWER_OFF_IN && !wr)[*4]
    |=> COUNT_VALUE_OUT == $past(COUNT_VALUE_OUT) + 8'h01)
    else $error("normal mode step wrong");
  a_ovf_wrap: assert property (wm == 3'h0 && !$past(wr)
    && $past(COUNT_VALUE_OUT) == 8'hff && COUNT_VALUE_OUT == 8'h00
    |-> ##[0:1] IRQ_FLAG_REG_OUT[0]) else $error("wrap without overflow");
  a_req_masked: assert property (IRQ_REQ_OUT ==
    (IRQ_FLAG_REG_OUT & $past(IRQ_MASK_REG_IN)))
    else $error("request not flag and mask");
  a_flag_sticky: assert property (($past(IRQ_FLAG_REG_OUT)
    & ~IRQ_FLAG_REG_OUT & ~($past(clr) | $past(clr, 2))) == 3'h0)
    else $error("flag fell without clear");
  a_cmp_direct: assert property (COMPARE_REG_A_WR_IN.wr && wm == 3'h0
    |-> ##2 COMPARE_REG_A_OUT == $past(COMPARE_REG_A_WR_IN.data, 2))
    else $error("direct compare write lost");
  a_cmp_buffered: assert property (wm == 3'h3 && $past(wm) == 3'h3
    && $changed(COMPARE_REG_A_OUT) |-> COUNT_VALUE_OUT inside {8'h00, 8'hff})
    else $error("buffered compare copied mid period");
  a_quiet_a: assert property ((COMPARE_OUTPUT_MODE_A_IN == 2'h0)[*3]
    |=> $stable(WAVE_OUT_A_OUT)) else $error("wave moved with mode none");
  c_match_a: cover property (IRQ_FLAG_REG_OUT[1]);
  c_buf_copy: cover property (wm == 3'h3 && $changed(COMPARE_REG_A_OUT));
  c_ovf_req: cover property (IRQ_REQ_OUT[0]);
endmodule : tmr8_assertions

bind tmr8_core tmr8_assertions tmr8_assertions_i (.*);

// ===== tmr8_core.sv
// 8-bit timer with two compare units, double buffering and pwm
// assumes software strobes are one-cycle pulses on the system clock
//
// Overview of operation
// - counter at bottom when 0x00, at maximum when 0xff
// - top is fixed 0xff or compare register a, by waveform mode
// - tick from prescaler tap or external pin edge per clock select
// - clock select zero stops counter; count still readable and writable
// - software count write beats clear, increment and decrement
// - each tick clears, increments or decrements counter per mode
// - three-bit waveform mode: two bits in ctrl a, one in ctrl b
// - overflow flag set at mode-defined point, offered as interrupt
// - counter compared with both compare registers at all times
// - match sets its unit flag on the following tick
// - flag clears on interrupt service or software writing one
// - three flags in one flag register, each masked separately
// - waveform outputs driven from matches per mode and output mode
// - compare registers double buffered in pwm modes only
// - buffered value copied to active register on the tick at top, never at bottom
// - software compare writes reach buffer when buffered, else active
// - force compare in non-pwm modes acts on output like a match
// - forced compare sets no flag and leaves the counter alone
// - count write blocks match flags and outputs on the next tick, even stopped; clear-on-match mode still clears on compare a
// - normal mode counts up, wraps 0xff to 0x00, overflow at zero
// - clear-on-match mode clears counter when it equals compare a
// - fast pwm counts bottom to top and restarts; mode 3 or 7
// - output mode zero leaves the output alone on a match
module tmr8_core (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic TIMER_POWER_OFF_IN,
  input wire logic [1:0] TIMER_CTRL_A_WAVEFORM_MODE_IN,
  input wire logic TIMER_CTRL_B_WAVEFORM_MODE_IN,
  input wire logic [2:0] CLOCK_SELECT_IN,
  input wire logic [1:0] COMPARE_OUTPUT_MODE_A_IN,
  input wire logic [1:0] COMPARE_OUTPUT_MODE_B_IN,
  input wire logic [1:0] FORCE_COMPARE_IN,
  input wire logic EXT_COUNT_PIN_IN,
  input wire tmr8_pkg::tmr8_wr_t COUNT_VALUE_WR_IN,
  input wire tmr8_pkg::tmr8_wr_t COMPARE_REG_A_WR_IN,
  input wire tmr8_pkg::tmr8_wr_t COMPARE_REG_B_WR_IN,
  input wire logic [2:0] IRQ_FLAG_REG_CLEAR_IN,
  input wire logic [2:0] IRQ_SERVICED_IN,
  input wire logic [2:0] IRQ_MASK_REG_IN,
  output logic [7:0] COUNT_VALUE_OUT,
  output logic [7:0] COMPARE_REG_A_OUT,
  output logic [7:0] COMPARE_REG_B_OUT,
  output logic [2:0] IRQ_FLAG_REG_OUT,
  output logic [2:0] IRQ_REQ_OUT,
  output logic WAVE_OUT_A_OUT,
  output logic WAVE_OUT_B_OUT
);

  // ************************************************************
  // decoding helpers
  // ************************************************************
  function automatic logic is_pwm(input logic [2:0] wm);
    is_pwm = (wm == tmr8_pkg::TMR8_WM_PC_MAX) ||
             (wm == tmr8_pkg::TMR8_WM_FAST_MAX) ||
             (wm == tmr8_pkg::TMR8_WM_PC_CMPA) ||
             (wm == tmr8_pkg::TMR8_WM_FAST_CMPA);
  endfunction : is_pwm

  function automatic logic is_phase(input logic [2:0] wm);
    is_phase = (wm == tmr8_pkg::TMR8_WM_PC_MAX) ||
               (wm == tmr8_pkg::TMR8_WM_PC_CMPA);
  endfunction : is_phase

  // action of a match on a wave bit in non-pwm modes
  function automatic logic match_act(input logic [1:0] com,
                                     input logic cur);
    unique case (com)
      tmr8_pkg::TMR8_COM_NONE: match_act = cur;
      tmr8_pkg::TMR8_COM_TOGGLE: match_act = ~cur;
      tmr8_pkg::TMR8_COM_CLEAR: match_act = 1'b0;
      tmr8_pkg::TMR8_COM_SET: match_act = 1'b1;
    endcase
  endfunction : match_act

  // top moves off 0xff only in the two modes that name compare a
  function automatic logic top_is_a(input logic [2:0] wm);
    top_is_a = (wm == tmr8_pkg::TMR8_WM_PC_CMPA) ||
               (wm == tmr8_pkg::TMR8_WM_FAST_CMPA);
  endfunction : top_is_a

  // ************************************************************
  // pwm waveform helpers
  // ************************************************************
  // fast pwm: a match moves the pin to com bit 0, the top tick undoes it
  function automatic logic fast_act(input logic [1:0] com,
                                    input logic hit,
                                    input logic top_tick,
                                    input logic cur);
    fast_act = cur;
    if (hit) begin
      fast_act = com[0];
    end else if (top_tick) begin
      fast_act = ~com[0];
    end
  endfunction : fast_act

  // phase correct: the match level flips with the count direction
  function automatic logic phase_act(input logic [1:0] com,
                                     input logic hit,
                                     input logic down,
                                     input logic cur);
    phase_act = cur;
    if (hit) begin
      phase_act = down ^ com[0];
    end
  endfunction : phase_act

  // ************************************************************
  // tick source
  // ************************************************************
  logic tick_raw;
  logic tick;
  logic [2:0] wmode;
  logic pwm;
  logic [7:0] top;
  logic at_top;
  logic at_bottom;
  logic [1:0] com [2];
  logic [1:0] match;
  logic phase;
  logic top_tick;

  tmr8_tick u_tick (
    .CLOCK_IN(CLOCK_IN),
    .RST_IN(RST_IN),
    .CLOCK_SELECT_IN(CLOCK_SELECT_IN),
    .EXT_COUNT_PIN_IN(EXT_COUNT_PIN_IN),
    .TIMER_TICK_OUT(tick_raw)
  );

  // powered-off timer sees no ticks; software keeps it cleared
  assign tick = tick_raw & ~TIMER_POWER_OFF_IN;

  tmr8_pkg::tmr8_st_t st_q;
  tmr8_pkg::tmr8_st_t st_d;

  // ************************************************************
  // mode decoding
  // ************************************************************
  assign wmode = {TIMER_CTRL_B_WAVEFORM_MODE_IN,
                  TIMER_CTRL_A_WAVEFORM_MODE_IN};
  assign pwm = is_pwm(wmode);
  assign phase = is_phase(wmode);
  assign top = top_is_a(wmode) ? st_q.cmp[0] : tmr8_pkg::TMR8_MAX;
  assign top_tick = tick && at_top;
  assign at_top = (st_q.count == top);
  assign at_bottom = (st_q.count == tmr8_pkg::TMR8_BOTTOM);
  assign com[0] = COMPARE_OUTPUT_MODE_A_IN;
  assign com[1] = COMPARE_OUTPUT_MODE_B_IN;

  // ************************************************************
  // comparators
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cmp
      assign match[gi] = (st_q.count == st_q.cmp[gi]);
    end
  endgenerate

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [1:0] hit;
    logic ovf;
    logic reload;
    logic [2:0] set;
    logic [7:0] nxt;
    logic [2:0] clr;
    hit = 2'b00;
    clr = 3'b000;
    ovf = 1'b0;
    reload = 1'b0;
    set = 3'b000;
    nxt = st_q.count;
    st_d = st_q;

    // a match seen on one tick is acted on at the next one
    if (tick) begin
      hit = st_q.match_pend;
      // a count write just before this tick masks what it would catch
      if (st_q.block) begin
        st_d.match_pend = 2'b00;
      end else begin
        st_d.match_pend = match;
      end
      st_d.block = 1'b0;
    end

    // counting sequence
    if (tick) begin
      unique case (wmode)
        tmr8_pkg::TMR8_WM_NORMAL: begin
          nxt = st_q.count + 8'h01;
          ovf = (st_q.count == tmr8_pkg::TMR8_MAX);
        end
        tmr8_pkg::TMR8_WM_CTC: begin
          if (match[0]) begin
            nxt = tmr8_pkg::TMR8_BOTTOM;
          end else begin
            nxt = st_q.count + 8'h01;
          end
          // a missed compare a lets the count run on past 0xff
          ovf = (st_q.count == tmr8_pkg::TMR8_MAX) && !match[0];
        end
        tmr8_pkg::TMR8_WM_FAST_MAX, tmr8_pkg::TMR8_WM_FAST_CMPA: begin
          if (at_top) begin
            nxt = tmr8_pkg::TMR8_BOTTOM;
          end else begin
            nxt = st_q.count + 8'h01;
          end
          ovf = at_top;
          reload = at_top;
        end
        tmr8_pkg::TMR8_WM_PC_MAX, tmr8_pkg::TMR8_WM_PC_CMPA: begin
          if (st_q.down) begin
            if (at_bottom) begin
              nxt = st_q.count + 8'h01;
              st_d.down = 1'b0;
            end else begin
              nxt = st_q.count - 8'h01;
            end
          end else begin
            if (at_top) begin
              nxt = st_q.count - 8'h01;
              st_d.down = 1'b1;
            end else begin
              nxt = st_q.count + 8'h01;
            end
          end
          ovf = at_bottom;
          reload = at_top;
        end
        default: begin
          // reserved codes count like normal mode rather than freeze
          nxt = st_q.count + 8'h01;
          ovf = (st_q.count == tmr8_pkg::TMR8_MAX);
        end
      endcase
      st_d.count = nxt;
    end

    // software count write wins and blocks the next tick's match flags and outputs
    if (COUNT_VALUE_WR_IN.wr) begin
      st_d.count = COUNT_VALUE_WR_IN.data;
      st_d.block = 1'b1;
    end

    // double buffering of compare registers
    if (pwm && reload) begin
      st_d.cmp = st_q.cmp_buf;
    end
    if (COMPARE_REG_A_WR_IN.wr) begin
      if (pwm) begin
        st_d.cmp_buf[0] = COMPARE_REG_A_WR_IN.data;
      end else begin
        st_d.cmp[0] = COMPARE_REG_A_WR_IN.data;
        st_d.cmp_buf[0] = COMPARE_REG_A_WR_IN.data;
      end
    end
    if (COMPARE_REG_B_WR_IN.wr) begin
      if (pwm) begin
        st_d.cmp_buf[1] = COMPARE_REG_B_WR_IN.data;
      end else begin
        st_d.cmp[1] = COMPARE_REG_B_WR_IN.data;
        st_d.cmp_buf[1] = COMPARE_REG_B_WR_IN.data;
      end
    end

    // flags: hardware set wins over a clear in the same cycle
    set[tmr8_pkg::TMR8_FLAG_OVF] = ovf;
    set[tmr8_pkg::TMR8_FLAG_MA] = hit[0];
    set[tmr8_pkg::TMR8_FLAG_MB] = hit[1];
    clr = IRQ_FLAG_REG_CLEAR_IN | IRQ_SERVICED_IN;
    st_d.flags = (st_q.flags & ~clr) | set;
    st_d.irq = st_d.flags & IRQ_MASK_REG_IN;

    // waveform generation
    for (int u = 0; u < 2; u++) begin
      if (!pwm) begin
        if (hit[u]) begin
          st_d.wave[u] = match_act(com[u], st_q.wave[u]);
        end
        // forcing touches the pin only, never flags or counter
        if (FORCE_COMPARE_IN[u]) begin
          st_d.wave[u] = match_act(com[u], st_q.wave[u]);
        end
      end else if (com[u][1]) begin
        // com 2 non-inverting, com 3 inverting; com 1 not supported
        if (phase) begin
          st_d.wave[u] = phase_act(com[u], hit[u], st_q.down,
                                   st_q.wave[u]);
        end else begin
          st_d.wave[u] = fast_act(com[u], hit[u], top_tick,
                                  st_q.wave[u]);
        end
      end
    end

    st_d.count_out = st_d.count;
    st_d.cmp_out = st_d.cmp;
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      st_q <= '{count: tmr8_pkg::TMR8_COUNT_RST,
                down: 1'b0,
                cmp: {tmr8_pkg::TMR8_CMP_RST, tmr8_pkg::TMR8_CMP_RST},
                cmp_buf: {tmr8_pkg::TMR8_CMP_RST, tmr8_pkg::TMR8_CMP_RST},
                flags: tmr8_pkg::TMR8_FLAGS_RST,
                irq: tmr8_pkg::TMR8_FLAGS_RST,
                block: 1'b0,
                match_pend: 2'b00,
                wave: 2'b00,
                count_out: tmr8_pkg::TMR8_COUNT_RST,
                cmp_out: {tmr8_pkg::TMR8_CMP_RST, tmr8_pkg::TMR8_CMP_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign COUNT_VALUE_OUT = st_q.count_out;
  assign COMPARE_REG_A_OUT = st_q.cmp_out[0];
  assign COMPARE_REG_B_OUT = st_q.cmp_out[1];
  assign IRQ_FLAG_REG_OUT = st_q.flags;
  assign IRQ_REQ_OUT = st_q.irq;
  assign WAVE_OUT_A_OUT = st_q.wave[0];
  assign WAVE_OUT_B_OUT = st_q.wave[1];

endmodule : tmr8_core

// ===== tmr8_partner.sv
// partner model: external pulse source on the count pin
// assumes enable_in changes only at falling edges of clock_in
module tmr8_partner (
  input wire logic clock_in,
  input wire logic enable_in,
  output logic ext_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned phase;
  initial begin
    ext_pin_out = 1'b0;
    phase = 0;
  end
  // three clocks a level keeps it above the one cycle sampling minimum
  // when disabled the pin holds, so no false edge at enable
  always @(negedge clock_in) begin
    if (enable_in) begin
      phase <= (phase == 2) ? 0 : phase + 1;
      if (phase == 2) ext_pin_out <= ~ext_pin_out;
    end
  end
endmodule : tmr8_partner

// ===== tmr8_pkg.sv
// package of constants and carrier types for the 8-bit dual compare timer
// assumes a single system clock; no register bus, all control is by ports
package tmr8_pkg;

  // ************************************************************
  // count limits
  // ************************************************************
  localparam logic [7:0] TMR8_BOTTOM = 8'h00;
  localparam logic [7:0] TMR8_MAX = 8'hff;

  // ************************************************************
  // clock select codes
  // ************************************************************
  localparam logic [2:0] TMR8_CS_STOP = 3'h0;
  localparam logic [2:0] TMR8_CS_DIV1 = 3'h1;
  localparam logic [2:0] TMR8_CS_DIV8 = 3'h2;
  localparam logic [2:0] TMR8_CS_DIV64 = 3'h3;
  localparam logic [2:0] TMR8_CS_DIV256 = 3'h4;
  localparam logic [2:0] TMR8_CS_DIV1024 = 3'h5;
  localparam logic [2:0] TMR8_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TMR8_CS_EXT_RISE = 3'h7;

  // ************************************************************
  // prescaler taps (terminal counts of a 10-bit free counter)
  // ************************************************************
  localparam logic [9:0] TMR8_TAP8 = 10'h007;
  localparam logic [9:0] TMR8_TAP64 = 10'h03f;
  localparam logic [9:0] TMR8_TAP256 = 10'h0ff;
  localparam logic [9:0] TMR8_TAP1024 = 10'h3ff;

  // ************************************************************
  // waveform modes
  // ************************************************************
  localparam logic [2:0] TMR8_WM_NORMAL = 3'h0;
  localparam logic [2:0] TMR8_WM_PC_MAX = 3'h1;
  localparam logic [2:0] TMR8_WM_CTC = 3'h2;
  localparam logic [2:0] TMR8_WM_FAST_MAX = 3'h3;
  localparam logic [2:0] TMR8_WM_PC_CMPA = 3'h5;
  localparam logic [2:0] TMR8_WM_FAST_CMPA = 3'h7;

  // ************************************************************
  // compare output modes and flag bit positions
  // ************************************************************
  localparam logic [1:0] TMR8_COM_NONE = 2'h0;
  localparam logic [1:0] TMR8_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TMR8_COM_CLEAR = 2'h2;
  localparam logic [1:0] TMR8_COM_SET = 2'h3;
  localparam int TMR8_FLAG_OVF = 0;
  localparam int TMR8_FLAG_MA = 1;
  localparam int TMR8_FLAG_MB = 2;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] TMR8_COUNT_RST = 8'h00;
  localparam logic [7:0] TMR8_CMP_RST = 8'h00;
  localparam logic [2:0] TMR8_FLAGS_RST = 3'h0;
  localparam logic [9:0] TMR8_PRE_RST = 10'h000;

  // software write strobe with its data
  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } tmr8_wr_t;

  // state of the tick selector
  typedef struct packed {
    logic [9:0] pre;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic tick;
  } tmr8_tick_st_t;

  // state of the main timer
  typedef struct packed {
    logic [7:0] count;
    logic down;
    logic [1:0][7:0] cmp;
    logic [1:0][7:0] cmp_buf;
    logic [2:0] flags;
    logic [2:0] irq;
    logic block;
    logic [1:0] match_pend;
    logic [1:0] wave;
    logic [7:0] count_out;
    logic [1:0][7:0] cmp_out;
  } tmr8_st_t;

endpackage : tmr8_pkg

// ===== tmr8_tick.sv
// timer tick selector: free prescaler and external pin edge detector
// assumes the count pin is synchronous to the system clock as sampled
module tmr8_tick (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic [2:0] CLOCK_SELECT_IN,
  input wire logic EXT_COUNT_PIN_IN,
  output logic TIMER_TICK_OUT
);

  tmr8_pkg::tmr8_tick_st_t st_q;
  tmr8_pkg::tmr8_tick_st_t st_d;

  // ************************************************************
  // tick selection
  // ************************************************************
  always_comb begin
    st_d = st_q;
    // prescaler runs free, independent of the selection
    st_d.pre = st_q.pre + 10'h001;
    st_d.ext_s1 = EXT_COUNT_PIN_IN;
    st_d.ext_s2 = st_q.ext_s1;
    st_d.ext_s3 = st_q.ext_s2;
    unique case (CLOCK_SELECT_IN)
      tmr8_pkg::TMR8_CS_STOP: st_d.tick = 1'b0;
      tmr8_pkg::TMR8_CS_DIV1: st_d.tick = 1'b1;
      tmr8_pkg::TMR8_CS_DIV8:
        st_d.tick = (st_q.pre[2:0] == tmr8_pkg::TMR8_TAP8[2:0]);
      tmr8_pkg::TMR8_CS_DIV64:
        st_d.tick = (st_q.pre[5:0] == tmr8_pkg::TMR8_TAP64[5:0]);
      tmr8_pkg::TMR8_CS_DIV256:
        st_d.tick = (st_q.pre[7:0] == tmr8_pkg::TMR8_TAP256[7:0]);
      tmr8_pkg::TMR8_CS_DIV1024:
        st_d.tick = (st_q.pre == tmr8_pkg::TMR8_TAP1024);
      tmr8_pkg::TMR8_CS_EXT_FALL:
        st_d.tick = st_q.ext_s3 & ~st_q.ext_s2;
      tmr8_pkg::TMR8_CS_EXT_RISE:
        st_d.tick = ~st_q.ext_s3 & st_q.ext_s2;
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      st_q <= '{pre: tmr8_pkg::TMR8_PRE_RST, default: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign TIMER_TICK_OUT = st_q.tick;

endmodule : tmr8_tick
